// *** rtl/oct_outq.sv ***
// Purpose: Small output queue for query answers
// Assumes: Push ignored when full, pop ignored when empty
// Notes:   Head comes out of a register, forwarded on push to empty
`timescale 1ns/1ps
module oct_outq #(
	parameter int W     = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// Queue link
	oct_q_if.mem      q
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wptr_r, rptr_r, rptr_nxt;
	logic [PW:0]   cnt_r;
	logic          do_push, do_pop;
	logic [W-1:0]  head_r;

	assign do_push = q.push && (cnt_r != DEPTH[PW:0]);
	assign do_pop  = q.pop && (cnt_r != '0);
	assign rptr_nxt = do_pop ? rptr_r + 1'b1 : rptr_r;
	assign q.head  = head_r;
	assign q.empty = (cnt_r == '0);
	assign q.full  = (cnt_r == DEPTH[PW:0]);

	always_ff @(posedge i_clock) begin
		if (do_push) begin
			mem_r[wptr_r] <= q.push_data;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r  <= '0;
			head_r <= '0;
		end else begin
			if (do_push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			rptr_r <= rptr_nxt;
			cnt_r  <= cnt_r + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
			// Forward so the head register never shows a stale slot
			if (do_push && (wptr_r == rptr_nxt)) begin
				head_r <= q.push_data;
			end else begin
				head_r <= mem_r[rptr_nxt];
			end
		end
	end
endmodule : oct_outq

// *** rtl/oct_pkg.sv ***
// Purpose: Types and register decode of the operation complete tracker
// Assumes: oct_regs.svh holds the numbers
// Notes:   Tracker states are one-hot
package oct_pkg;
`include "oct_regs.svh"
	typedef enum logic [1:0] {
		OCT_TRK_IDLE = 2'b01,
		OCT_TRK_ACT  = 2'b10
	} oct_trk_t;

	typedef enum logic [2:0] {
		OCT_REG_NONE, OCT_REG_CMD, OCT_REG_CFG,
		OCT_REG_STAT, OCT_REG_ESR, OCT_REG_OUTQ
	} oct_reg_t;

	function automatic oct_reg_t oct_decode(input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:2], 2'b00};
		case (a)
			`OCT_ADDR_CMD:  oct_decode = OCT_REG_CMD;
			`OCT_ADDR_CFG:  oct_decode = OCT_REG_CFG;
			`OCT_ADDR_STAT: oct_decode = OCT_REG_STAT;
			`OCT_ADDR_ESR:  oct_decode = OCT_REG_ESR;
			`OCT_ADDR_OUTQ: oct_decode = OCT_REG_OUTQ;
			default:        oct_decode = OCT_REG_NONE;
		endcase
	endfunction : oct_decode
endpackage : oct_pkg

// *** rtl/oct_q_if.sv ***
// Purpose: Push/pop link between tracker and output queue
// Assumes: One clock
// Notes:   head is the registered oldest byte
`timescale 1ns/1ps
interface oct_q_if #(parameter int W = 8);
	logic         push;
	logic [W-1:0] push_data;
	logic         pop;
	logic [W-1:0] head;
	logic         empty;
	logic         full;
	modport src (output push, push_data, pop, input head, empty, full);
	modport mem (input push, push_data, pop, output head, empty, full);
endinterface : oct_q_if

// *** rtl/oct_regs.svh ***
// Purpose: Register map, field positions and constants of the tracker
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes:   Definitions only
`ifndef OCT_REGS_SVH
`define OCT_REGS_SVH
// ==========================================================
// Register byte offsets
`define OCT_ADDR_CMD      8'h00
`define OCT_ADDR_CFG      8'h04
`define OCT_ADDR_STAT     8'h08
`define OCT_ADDR_ESR      8'h0c
`define OCT_ADDR_OUTQ     8'h10
// ==========================================================
// Command register bits (write one to issue)
`define OCT_CMD_OPC       0
`define OCT_CMD_OPCQ      1
`define OCT_CMD_INIT      2
`define OCT_CMD_CONT_ON   3
`define OCT_CMD_CONT_OFF  4
`define OCT_CMD_TRG       5
`define OCT_CMD_ABORT     6
`define OCT_CMD_CLS       7
`define OCT_CMD_RST       8
`define OCT_CMD_DCL       9
`define OCT_CMD_W         10
`define OCT_CMD_DCL_MASK  10'h200
// ==========================================================
// Configuration, event and status fields
`define OCT_CFG_POFL      0
`define OCT_CFG_POFL_RST  1'b0
`define OCT_ESR_OPC       0
`define OCT_STB_MAV       4
`define OCT_ST_STB_LSB    8
`define OCT_ST_QACT       16
`define OCT_ST_CACT       17
`define OCT_ST_INITP      18
`define OCT_ST_TRGP       19
`define OCT_ST_CONT       20
// ==========================================================
// Misc constants
`define OCT_ASCII_ONE     8'h31
`define OCT_INIT_GUARD    2'd2
`define OCT_RESP_OKAY     2'b00
`define OCT_RESP_SLVERR   2'b10
`endif

// *** rtl/oct_tracker.sv ***
// Purpose: Operation complete command and query tracker, AXI4-Lite slave
// Assumes: Trigger engine signals are on i_clock; engine leaves idle
//          within two cycles of o_initiate
// Notes:   A query locks command writes other than device clear until pending work finishes or a device clear
`timescale 1ns/1ps
`include "oct_regs.svh"
module oct_tracker
	import oct_pkg::*;
#(
	parameter int QDEPTH = 4
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// AXI4-Lite write
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// AXI4-Lite read
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// Trigger and measurement engine
	input  wire logic        i_seq_idle,
	input  wire logic        i_no_op_pending,
	input  wire logic        i_trg_done,
	input  wire logic        i_ctl_wait,
	output logic             o_initiate,
	output logic             o_abort,
	output logic             o_bus_trigger,
	output logic             o_cont_on,
	// Status
	output logic             o_opc_bit,
	output logic             o_mav,
	output logic             o_locked
);
	import oct_pkg::*;

	// ==========================================================
	// Declarations
	oct_q_if #(.W(8)) q ();
	logic                 aw_hold_r, w_hold_r, ar_hold_r;
	logic [7:0]           aw_addr_r, ar_addr_r;
	logic [31:0]          w_data_r;
	logic [3:0]           w_strb_r;
	logic                 awready_r, wready_r, arready_r;
	logic                 bvalid_r, rvalid_r;
	logic [1:0]           bresp_r, rresp_r;
	logic [31:0]          rdata_r;
	logic                 wr_go, rd_go;
	oct_reg_t             wr_reg, rd_reg;
	logic [`OCT_CMD_W-1:0] cmd, cmd_ok;
	logic                 refused;
	logic                 pofl_r;
	oct_trk_t             q_state_r, c_state_r;
	logic                 init_pend_r, trg_pend_r, cont_r;
	logic [1:0]           guard_r;
	logic                 ctl_wait_d_r;
	logic                 esr_opc_r;
	logic                 all_done, init_done, clr, init_set;
	logic                 q_act, c_act;
	logic                 initiate_r, abort_r, bus_trg_r, mav_r;
	logic [7:0]           stb;
	logic [31:0]          rd_mux;
	logic                 rd_err;

	assign wr_go  = aw_hold_r && w_hold_r && !bvalid_r;
	assign rd_go  = ar_hold_r && !rvalid_r;
	assign wr_reg = oct_decode(aw_addr_r);
	assign rd_reg = oct_decode(ar_addr_r);
	assign q_act  = (q_state_r == OCT_TRK_ACT);
	assign c_act  = (c_state_r == OCT_TRK_ACT);

	// ==========================================================
	// AXI4-Lite channel handshakes
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			ar_hold_r <= 1'b0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			arready_r <= 1'b1;
			aw_addr_r <= 8'h00;
			ar_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
		end else begin
			if (i_awvalid && awready_r) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= i_awaddr;
				awready_r <= 1'b0;
			end else if (wr_go) begin
				aw_hold_r <= 1'b0;
			end else if (bvalid_r && i_bready) begin
				awready_r <= 1'b1;
			end
			if (i_wvalid && wready_r) begin
				w_hold_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
				wready_r <= 1'b0;
			end else if (wr_go) begin
				w_hold_r <= 1'b0;
			end else if (bvalid_r && i_bready) begin
				wready_r <= 1'b1;
			end
			if (i_arvalid && arready_r) begin
				ar_hold_r <= 1'b1;
				ar_addr_r <= i_araddr;
				arready_r <= 1'b0;
			end else if (rd_go) begin
				ar_hold_r <= 1'b0;
			end else if (rvalid_r && i_rready) begin
				arready_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Command decode; only the device clear bit passes a locked tracker
	always_comb begin
		cmd = '0;
		if (wr_go && (wr_reg == OCT_REG_CMD) && w_strb_r[0] && w_strb_r[1]) begin
			cmd = w_data_r[`OCT_CMD_W-1:0];
		end
	end
	assign cmd_ok  = q_act ? (cmd & `OCT_CMD_DCL_MASK) : cmd;
	assign refused = q_act && ((cmd & ~`OCT_CMD_DCL_MASK) != '0);
	assign clr     = cmd_ok[`OCT_CMD_RST] || cmd_ok[`OCT_CMD_CLS] ||
	                 cmd_ok[`OCT_CMD_DCL];

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `OCT_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (wr_reg == OCT_REG_NONE || refused) ?
			            `OCT_RESP_SLVERR : `OCT_RESP_OKAY;
		end else if (bvalid_r && i_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			pofl_r <= `OCT_CFG_POFL_RST;
		end else if (wr_go && wr_reg == OCT_REG_CFG && w_strb_r[0]) begin
			pofl_r <= w_data_r[`OCT_CFG_POFL];
		end
	end

	// ==========================================================
	// Pending overlapped work
	// Initiate counts done only once the sequencer idles; the guard hides
	// the idle level still showing right after the start pulse.
	assign init_set  = cmd_ok[`OCT_CMD_INIT] || cmd_ok[`OCT_CMD_CONT_ON];
	assign init_done = (guard_r == 2'd0) && i_seq_idle &&
	                   (!pofl_r || i_no_op_pending);
	assign all_done  = !init_pend_r && !trg_pend_r;

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			init_pend_r <= 1'b0;
			guard_r     <= 2'd0;
		end else if (init_set) begin
			init_pend_r <= 1'b1;
			guard_r     <= `OCT_INIT_GUARD;
		end else begin
			if (guard_r != 2'd0) begin
				guard_r <= guard_r - 2'd1;
			end
			if (cmd_ok[`OCT_CMD_ABORT] || cmd_ok[`OCT_CMD_RST] || init_done) begin
				init_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			trg_pend_r   <= 1'b0;
			ctl_wait_d_r <= 1'b0;
		end else begin
			ctl_wait_d_r <= i_ctl_wait;
			if (cmd_ok[`OCT_CMD_TRG]) begin
				trg_pend_r <= 1'b1;
			end else if (cmd_ok[`OCT_CMD_RST] || i_trg_done ||
			             (i_ctl_wait && !ctl_wait_d_r)) begin
				trg_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cont_r <= 1'b0;
		end else if (cmd_ok[`OCT_CMD_CONT_ON]) begin
			cont_r <= 1'b1;
		end else if (cmd_ok[`OCT_CMD_CONT_OFF] || cmd_ok[`OCT_CMD_RST]) begin
			cont_r <= 1'b0;
		end
	end

	// ==========================================================
	// Query tracker
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			q_state_r <= OCT_TRK_IDLE;
		end else if (clr) begin
			q_state_r <= OCT_TRK_IDLE;
		end else begin
			case (q_state_r)
				OCT_TRK_IDLE: begin
					if (cmd_ok[`OCT_CMD_OPCQ]) begin
						q_state_r <= OCT_TRK_ACT;
					end
				end
				OCT_TRK_ACT: begin
					if (all_done) begin
						q_state_r <= OCT_TRK_IDLE;
					end
				end
				default: q_state_r <= OCT_TRK_IDLE;
			endcase
		end
	end
	// A full queue drops the answer rather than stalling the tracker
	assign q.push      = q_act && all_done && !clr;
	assign q.push_data = `OCT_ASCII_ONE;
	assign q.pop       = rd_go && (rd_reg == OCT_REG_OUTQ);

	oct_outq #(.W(8), .DEPTH(QDEPTH)) u_outq (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.q       (q)
	);

	// ==========================================================
	// Command tracker and event status bit
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			c_state_r <= OCT_TRK_IDLE;
		end else if (clr) begin
			c_state_r <= OCT_TRK_IDLE;
		end else begin
			case (c_state_r)
				OCT_TRK_IDLE: begin
					if (cmd_ok[`OCT_CMD_OPC]) begin
						c_state_r <= OCT_TRK_ACT;
					end
				end
				OCT_TRK_ACT: begin
					if (all_done) begin
						c_state_r <= OCT_TRK_IDLE;
					end
				end
				default: c_state_r <= OCT_TRK_IDLE;
			endcase
		end
	end

	// Set wins over a read-clear landing in the same cycle
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			esr_opc_r <= 1'b0;
		end else if (c_act && all_done && !clr) begin
			esr_opc_r <= 1'b1;
		end else if (cmd_ok[`OCT_CMD_CLS] ||
		             (rd_go && rd_reg == OCT_REG_ESR)) begin
			esr_opc_r <= 1'b0;
		end
	end

	// ==========================================================
	// Read path
	always_comb begin
		stb = 8'h00;
		stb[`OCT_STB_MAV] = !q.empty;
		rd_mux = 32'h0000_0000;
		rd_err = 1'b0;
		case (rd_reg)
			OCT_REG_CFG:  rd_mux[`OCT_CFG_POFL] = pofl_r;
			OCT_REG_STAT: begin
				rd_mux[`OCT_ESR_OPC] = esr_opc_r;
				rd_mux[`OCT_ST_STB_LSB +: 8] = stb;
				rd_mux[`OCT_ST_QACT]  = q_act;
				rd_mux[`OCT_ST_CACT]  = c_act;
				rd_mux[`OCT_ST_INITP] = init_pend_r;
				rd_mux[`OCT_ST_TRGP]  = trg_pend_r;
				rd_mux[`OCT_ST_CONT]  = cont_r;
			end
			OCT_REG_ESR:  rd_mux[`OCT_ESR_OPC] = esr_opc_r;
			OCT_REG_OUTQ: rd_mux[7:0] = q.empty ? 8'h00 : q.head;
			OCT_REG_CMD:  rd_mux = 32'h0000_0000;
			default:      rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `OCT_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_err ? `OCT_RESP_SLVERR : `OCT_RESP_OKAY;
		end else if (rvalid_r && i_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ==========================================================
	// Engine strobes and status outputs
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			initiate_r <= 1'b0;
			abort_r    <= 1'b0;
			bus_trg_r  <= 1'b0;
			mav_r      <= 1'b0;
		end else begin
			initiate_r <= init_set;
			abort_r    <= cmd_ok[`OCT_CMD_ABORT] || cmd_ok[`OCT_CMD_RST];
			bus_trg_r  <= cmd_ok[`OCT_CMD_TRG];
			mav_r      <= !q.empty;
		end
	end

	assign o_awready     = awready_r;
	assign o_wready      = wready_r;
	assign o_bvalid      = bvalid_r;
	assign o_bresp       = bresp_r;
	assign o_arready     = arready_r;
	assign o_rvalid      = rvalid_r;
	assign o_rdata       = rdata_r;
	assign o_rresp       = rresp_r;
	assign o_initiate    = initiate_r;
	assign o_abort       = abort_r;
	assign o_bus_trigger = bus_trg_r;
	assign o_cont_on     = cont_r;
	assign o_opc_bit     = esr_opc_r;
	assign o_mav         = mav_r;
	assign o_locked      = q_act;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	query_enter_a: assert property (cmd_ok[`OCT_CMD_OPCQ] && !clr |=> q_act)
		else $error("query did not enter active");
	query_push_a: assert property (q_act && all_done && !clr && !q.full
		&& !q.pop |=> !q.empty && !q_act)
		else $error("query completion not queued");
	query_now_a: assert property (cmd_ok[`OCT_CMD_OPCQ] && !q_act && all_done
		&& !clr && !init_set && !cmd_ok[`OCT_CMD_TRG] |=> q_act ##1 !q_act)
		else $error("idle query not answered at once");
	init_hold_a: assert property (q_act && init_pend_r && !clr
		|=> q_act)
		else $error("answer given with initiate pending");
	trg_hold_a: assert property (q_act && trg_pend_r && !clr |=> q_act)
		else $error("answer given with trigger pending");
	pofl_hold_a: assert property (init_pend_r && pofl_r && !i_no_op_pending
		&& !init_set && !cmd_ok[`OCT_CMD_ABORT] && !cmd_ok[`OCT_CMD_RST]
		|=> init_pend_r)
		else $error("initiate done ignoring pending flag");
	trg_done_a: assert property (trg_pend_r && i_trg_done
		&& !cmd_ok[`OCT_CMD_TRG] |=> !trg_pend_r)
		else $error("trigger completion missed");
	opc_wait_a: assert property (c_act && !all_done && !esr_opc_r
		|=> !esr_opc_r)
		else $error("event bit set too early");
	opc_set_a: assert property (c_act && all_done && !clr
		|=> esr_opc_r && !c_act)
		else $error("event bit not set on completion");
	abort_done_a: assert property (cmd_ok[`OCT_CMD_ABORT] && !init_set
		|=> !init_pend_r ##0 o_abort)
		else $error("abort did not complete initiate");
	reset_cancel_a: assert property (cmd_ok[`OCT_CMD_RST] |=> !init_pend_r
		&& !trg_pend_r && !q_act && !c_act)
		else $error("reset left work pending");
	lock_refuse_a: assert property (refused |=> o_bvalid
		&& o_bresp == `OCT_RESP_SLVERR)
		else $error("locked command not refused");
	dcl_unlock_a: assert property (cmd_ok[`OCT_CMD_DCL] |=> !q_act
		&& !c_act)
		else $error("device clear left tracker active");
	talk_read_a: assert property (q.pop && !q.empty |=> o_rvalid
		&& o_rdata[7:0] == `OCT_ASCII_ONE)
		else $error("queued answer not sent");

	cover_query_c: cover property (q_act ##[1:20] q.push);
	cover_opc_c:   cover property (c_act && trg_pend_r ##[1:20] esr_opc_r);
	cover_dcl_c:   cover property (q_act && cont_r ##1 cmd_ok[`OCT_CMD_DCL]);
endmodule : oct_tracker

// *** verif/oct_engine_model.sv ***
// Purpose: Trigger and measurement engine stand-in facing the tracker
// Assumes: Same clock as the tracker
// Notes:   Busy time comes from the bench; continuous mode reloads on idle and never counts down
`timescale 1ns/1ps
module oct_engine_model (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// Tracker strobes
	input  wire logic       i_initiate,
	input  wire logic       i_abort,
	input  wire logic       i_bus_trigger,
	input  wire logic       i_cont,
	// Bench knobs
	input  wire logic [7:0] i_busy_len,
	input  wire logic [3:0] i_noop_lag,
	input  wire logic       i_trg_mode,
	// Engine status
	output logic            o_seq_idle,
	output logic            o_no_op_pending,
	output logic            o_trg_done,
	output logic            o_ctl_wait
);
	// ==========================================================
	// Sequencer
	logic [7:0] seq_cnt_r;
	logic [7:0] trg_cnt_r;
	logic [3:0] lag_r;
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			seq_cnt_r <= 8'h00;
		end else if (i_abort) begin
			seq_cnt_r <= 8'h00;
		end else if (i_initiate || (i_cont && o_seq_idle)) begin
			seq_cnt_r <= i_busy_len;
		end else if (seq_cnt_r != 8'h00 && !i_cont) begin
			seq_cnt_r <= seq_cnt_r - 8'h01;
		end
	end
	assign o_seq_idle = (seq_cnt_r == 8'h00);
	// Flag trails idle so the inclusion select has something to decide
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			lag_r <= 4'h0;
		end else if (!o_seq_idle) begin
			lag_r <= i_noop_lag;
		end else if (lag_r != 4'h0) begin
			lag_r <= lag_r - 4'h1;
		end
	end
	assign o_no_op_pending = o_seq_idle && (lag_r == 4'h0);
	// ==========================================================
	// Bus trigger: action done pulse or halt at control source
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			trg_cnt_r  <= 8'h00;
			o_trg_done <= 1'b0;
			o_ctl_wait <= 1'b0;
		end else begin
			o_trg_done <= 1'b0;
			if (i_bus_trigger) begin
				trg_cnt_r  <= i_busy_len;
				o_ctl_wait <= 1'b0;
			end else if (trg_cnt_r != 8'h00) begin
				trg_cnt_r <= trg_cnt_r - 8'h01;
				if (trg_cnt_r == 8'h01) begin
					o_trg_done <= !i_trg_mode;
					o_ctl_wait <= i_trg_mode;
				end
			end
		end
	end
endmodule : oct_engine_model

// *** verif/operation_complete_tracker_tb_top.sv ***
// Purpose: Self-checking bench of the operation complete tracker
// Assumes: AXI4-Lite master tasks, engine model on the far side
// Notes:   Expected answers are queued by the driver, checked by a monitor
`timescale 1ns/1ps
module operation_complete_tracker_tb_top;
	import oct_pkg::*;
`include "oct_regs.svh"
	// ==========================================================
	// Signals
	logic        i_clock = 1'b0, i_rst = 1'b1;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic        i_arvalid = 1'b0, i_rready = 1'b0;
	logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00, busy = 8'h14;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [3:0]  i_wstrb = 4'hf, lag = 4'h0;
	logic        mode = 1'b0, o_awready, o_wready, o_bvalid, o_arready;
	logic        o_rvalid, i_seq_idle, i_no_op_pending, i_trg_done;
	logic        i_ctl_wait, o_initiate, o_abort, o_bus_trigger, o_cont_on;
	logic        o_opc_bit, o_mav, o_locked;
	logic [1:0]  o_bresp, o_rresp, bq[$];
	logic [33:0] rq[$];
	int          fail_count = 0, samples_checked = 0, cyc = 0, i;
	int          n_init = 0, n_abort = 0, n_trg = 0;
	always #2.5 i_clock = ~i_clock;
	oct_tracker oct_tracker_inst (.i_clock, .i_rst, .i_awvalid, .o_awready,
		.i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid,
		.i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
		.i_rready, .o_rdata, .o_rresp, .i_seq_idle, .i_no_op_pending,
		.i_trg_done, .i_ctl_wait, .o_initiate, .o_abort, .o_bus_trigger,
		.o_cont_on, .o_opc_bit, .o_mav, .o_locked);
	oct_engine_model oct_engine_model_inst (.i_clock, .i_rst,
		.i_initiate(o_initiate), .i_abort(o_abort),
		.i_bus_trigger(o_bus_trigger), .i_cont(o_cont_on),
		.i_busy_len(busy), .i_noop_lag(lag), .i_trg_mode(mode),
		.o_seq_idle(i_seq_idle), .o_no_op_pending(i_no_op_pending),
		.o_trg_done(i_trg_done), .o_ctl_wait(i_ctl_wait));
	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	always @(posedge i_clock) begin
		if (o_rvalid && i_rready) chk({o_rresp, o_rdata}, rq.pop_front());
		if (o_bvalid && i_bready) chk({32'h0, o_bresp}, {32'h0, bq.pop_front()});
		cyc <= cyc + 1;
		// Strobe pulses are counted and checked once at the end
		if (o_initiate) n_init <= n_init + 1;
		if (o_abort) n_abort <= n_abort + 1;
		if (o_bus_trigger) n_trg <= n_trg + 1;
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ==========================================================
	// AXI4-Lite master
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = `OCT_RESP_OKAY);
		bq.push_back(r);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		i_bready <= 1'b0;
		// One idle edge so the next call never re-drives bready in this step
		@(posedge i_clock);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = `OCT_RESP_OKAY);
		rq.push_back({r, d});
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		i_rready <= 1'b0;
		@(posedge i_clock);
	endtask : rd
	task automatic idle_wait();
		while (o_locked !== 1'b0) @(posedge i_clock);
		repeat (4) @(posedge i_clock);
	endtask : idle_wait
	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(32'hff58));
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		rd(`OCT_ADDR_STAT, 32'h0);
		rd(`OCT_ADDR_CFG, 32'h0);
		rd(8'h20, 32'h0, `OCT_RESP_SLVERR);
		wr(8'h20, 32'h1, `OCT_RESP_SLVERR);
		// Query with nothing pending answers at once
		wr(`OCT_ADDR_CMD, 32'h2);
		repeat (4) @(posedge i_clock);
		chk(o_mav, 1'b1);
		rd(`OCT_ADDR_STAT, 32'h1000);
		rd(`OCT_ADDR_OUTQ, 32'h31);
		rd(`OCT_ADDR_OUTQ, 32'h0);
		chk(o_mav, 1'b0);
		// Initiate then query: locked, refused, answer after idle
		busy <= 8'd20 + 8'($urandom % 20);
		wr(`OCT_ADDR_CMD, 32'h4);
		wr(`OCT_ADDR_CMD, 32'h2);
		rd(`OCT_ADDR_STAT, 32'h0005_0000);
		wr(`OCT_ADDR_CMD, 32'h10, `OCT_RESP_SLVERR);
		idle_wait();
		rd(`OCT_ADDR_OUTQ, 32'h31);
		// Inclusion select makes the trailing flag count
		lag <= 4'ha;
		wr(`OCT_ADDR_CFG, 32'h1);
		wr(`OCT_ADDR_CMD, 32'h4);
		wr(`OCT_ADDR_CMD, 32'h2);
		while (i_seq_idle !== 1'b0) @(posedge i_clock);
		while (i_seq_idle !== 1'b1) @(posedge i_clock);
		rd(`OCT_ADDR_STAT, 32'h0005_0000);
		idle_wait();
		rd(`OCT_ADDR_OUTQ, 32'h31);
		wr(`OCT_ADDR_CFG, 32'h0);
		// Bus trigger alone, both ways of finishing
		for (i = 0; i < 2; i++) begin
			mode <= i[0];
			wr(`OCT_ADDR_CMD, 32'h40);
			wr(`OCT_ADDR_CMD, 32'h20);
			wr(`OCT_ADDR_CMD, 32'h1);
			rd(`OCT_ADDR_STAT, 32'h000a_0000);
			while (o_opc_bit !== 1'b1) @(posedge i_clock);
			rd(`OCT_ADDR_ESR, 32'h1);
			rd(`OCT_ADDR_ESR, 32'h0);
			chk(o_opc_bit, 1'b0);
		end
		// Continuous initiate then query locks until device clear
		wr(`OCT_ADDR_CMD, 32'h8);
		wr(`OCT_ADDR_CMD, 32'h2);
		repeat (5) @(posedge i_clock);
		rd(`OCT_ADDR_STAT, 32'h0015_0000);
		chk({o_locked, o_cont_on}, 2'b11);
		wr(`OCT_ADDR_CMD, 32'h2, `OCT_RESP_SLVERR);
		wr(`OCT_ADDR_CMD, `OCT_CMD_DCL_MASK);
		chk({o_locked, o_cont_on}, 2'b01);
		rd(`OCT_ADDR_STAT, 32'h0014_0000);
		wr(`OCT_ADDR_CMD, 32'h10);
		wr(`OCT_ADDR_CMD, 32'h40);
		rd(`OCT_ADDR_STAT, 32'h0);
		// Reset and clear status drop an owed completion
		for (i = 0; i < 2; i++) begin
			wr(`OCT_ADDR_CMD, 32'h4);
			wr(`OCT_ADDR_CMD, 32'h1);
			wr(`OCT_ADDR_CMD, i ? 32'h80 : 32'h100);
			while (i_seq_idle !== 1'b1) @(posedge i_clock);
			repeat (8) @(posedge i_clock);
			rd(`OCT_ADDR_ESR, 32'h0);
		end
		chk(34'(n_init), 34'd5);
		chk(34'(n_abort), 34'd4);
		chk(34'(n_trg), 34'd2);
		wrap_up();
	end
endmodule : operation_complete_tracker_tb_top
